// >>> core/oeac_pkg.sv
// constants, types and settings for the occupancy event action controller
// Operation
// - lamp control has three sensor settings: disabled (events ignored), occupancy, motion.
// - in occupancy mode an occupancy event runs the lamp action; the sensor enables its events.
// - in motion mode a motion event runs the action; the sensor enables its movement events.
// - a detection sets lamps to a level 0 to 254 or recalls a scene 0 to 15, as selected.
// - each lamp target holds a yes/no setting for automatic switch-off.
// - with switch-off on, lamps stay on for a 00:00 to 59:59 delay after motion stops, then go off; the delay fields accept up to 63:63.
// - relay control has three sensor settings: disabled (relay untouched), occupancy, motion.
// - a detection drives the relay on or off as the relay detection action says.
// - with relay toggling off, the relay keeps the state the detection gave it.
// - with relay toggling on, the relay returns to its former state after a 00:00 to 59:59 hold; the hold fields accept up to 63:63.
package oeac_pkg;

  // bus geometry
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_LAMP_CTRL = 8'h00;
  localparam logic [7:0] OFS_LAMP_VAL = 8'h04;
  localparam logic [7:0] OFS_LAMP_DELAY = 8'h08;
  localparam logic [7:0] OFS_RELAY_CTRL = 8'h0c;
  localparam logic [7:0] OFS_RELAY_HOLD = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam int OFS_W = 8;

  // field positions
  localparam int F_MODE_LO = 0;
  localparam int F_ACT = 2;
  localparam int F_AUTO = 3;
  localparam int F_LEVEL_LO = 0;
  localparam int F_SCENE_LO = 8;
  localparam int F_SEC_LO = 0;
  localparam int F_MIN_LO = 8;
  localparam int ST_RELAY = 0;
  localparam int ST_HOLD = 1;
  localparam int ST_DELAY = 2;
  localparam int ST_LAMP = 3;

  // field widths and limits
  localparam int MODE_W = 2;
  localparam int LEVEL_W = 8;
  localparam int SCENE_W = 4;
  localparam int TIME_FLD_W = 6;
  localparam int SECS_W = 12;
  localparam logic [LEVEL_W-1:0] LEVEL_MAX = 8'hfe;
  localparam logic [SECS_W-1:0] SECS_PER_MIN = 12'h03c;

  // timing: one countdown tick per second
  localparam longint CLK_FREQ_KHZ = 200000;
  localparam longint TICK_PERIOD_MS = 1000;
  localparam int TICK_CYCLES = int'(CLK_FREQ_KHZ * TICK_PERIOD_MS);

  // sensor settings, shared by lamp and relay
  typedef enum logic [MODE_W-1:0] {
    MODE_OFF = 2'h0,
    MODE_OCC = 2'h1,
    MODE_MOTION = 2'h2
  } oeac_mode_t;

  typedef enum logic [1:0] {
    CMD_LEVEL = 2'h0,
    CMD_SCENE = 2'h1,
    CMD_OFF = 2'h2
  } oeac_cmd_kind_t;

  typedef struct packed {
    logic [MODE_W-1:0] mode;
    logic act_scene;
    logic auto_off;
    logic [LEVEL_W-1:0] level;
    logic [SCENE_W-1:0] scene;
    logic [TIME_FLD_W-1:0] dmin;
    logic [TIME_FLD_W-1:0] dsec;
  } oeac_lamp_cfg_t;

  typedef struct packed {
    logic [MODE_W-1:0] mode;
    logic act_on;
    logic toggle;
    logic [TIME_FLD_W-1:0] hmin;
    logic [TIME_FLD_W-1:0] hsec;
  } oeac_relay_cfg_t;

  // lamp command toward the lighting bus sender
  typedef struct packed {
    logic valid;
    oeac_cmd_kind_t kind;
    logic [LEVEL_W-1:0] arg;
  } oeac_lamp_cmd_t;

  localparam oeac_lamp_cfg_t LAMP_CFG_RST = '0;
  localparam oeac_relay_cfg_t RELAY_CFG_RST = '0;

endpackage : oeac_pkg

// >>> core/oeac_tick.sv
// one-cycle pulse every tick period
`timescale 1ns/10ps
module oeac_tick #(
  parameter int unsigned PERIOD = 200000000
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick_q
);
  import oeac_pkg::*;

  logic [31:0] cnt_q, cnt_d;
  logic tick_d;

  // free-running divider, so a countdown may lose up to one period at its start
  always_comb begin
    cnt_d = cnt_q + 32'h1;
    tick_d = 1'b0;
    if (cnt_q >= PERIOD - 1) begin
      cnt_d = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end
endmodule : oeac_tick

// >>> core/oeac_countdown.sv
// reloadable seconds countdown with done pulse
`timescale 1ns/10ps
module oeac_countdown #(
  parameter int W = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic cancel,
  input wire logic tick,
  output logic busy_q,
  output logic done_q
);
  import oeac_pkg::*;

  logic [W-1:0] cnt_q, cnt_d;
  logic busy_d, done_d;

  // load beats cancel and expiry, so a fresh start is never lost
  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (load) begin
      cnt_d = load_val;
      busy_d = 1'b1;
    end else if (cancel) begin
      busy_d = 1'b0;
    end else if (busy_q && tick) begin
      if (cnt_q == '0) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end
endmodule : oeac_countdown

// >>> core/oeac_top.sv
// occupancy event action controller: bus registers, lamp and relay actions
`timescale 1ns/10ps
module oeac_top #(
  parameter int unsigned TICK_CYCLES_P = oeac_pkg::TICK_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [oeac_pkg::ADDR_W-1:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [oeac_pkg::DATA_W-1:0] HWDATA,
  input wire logic HREADY,
  output logic [oeac_pkg::DATA_W-1:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic OCC_EVT,
  input wire logic IDLE_EVT,
  input wire logic MOTION_EVT,
  input wire logic NOMOTION_EVT,
  output oeac_pkg::oeac_lamp_cmd_t LAMP_CMD,
  output logic RELAY_ON
);
  import oeac_pkg::*;

  // min:sec field pair to whole seconds
  function automatic logic [SECS_W-1:0] to_secs(input logic [TIME_FLD_W-1:0] mins,
                                                input logic [TIME_FLD_W-1:0] secs);
    logic [2*SECS_W-1:0] prod;
    prod = {{SECS_W{1'b0}}, {(SECS_W-TIME_FLD_W){1'b0}}, mins} * {{SECS_W{1'b0}}, SECS_PER_MIN};
    to_secs = prod[SECS_W-1:0] + {{(SECS_W-TIME_FLD_W){1'b0}}, secs};
  endfunction : to_secs

  // detection and vacancy decode per sensor setting
  function automatic logic detect(input logic [MODE_W-1:0] mode, input logic occ,
                                  input logic mot);
    detect = (mode == MODE_OCC && occ) || (mode == MODE_MOTION && mot);
  endfunction : detect

  // ---------------- bus slave ----------------
  oeac_lamp_cfg_t lamp_cfg_q, lamp_cfg_d;
  oeac_relay_cfg_t relay_cfg_q, relay_cfg_d;
  logic wr_pend_q, wr_pend_d;
  logic rd_pend_q, rd_pend_d;
  logic [OFS_W-1:0] ofs_q, ofs_d;
  logic [DATA_W-1:0] hrdata_d;
  logic hready_d;
  logic [DATA_W-1:0] status_w;
  logic addr_ok;

  // relay, lamp and timer state read back through status
  logic relay_q, relay_d;
  logic saved_q, saved_d;
  logic lamp_on_q, lamp_on_d;
  logic hold_busy, hold_done, delay_busy, delay_done;

  assign addr_ok = HSEL && HTRANS[1] && HREADY;

  always_comb begin
    status_w = '0;
    status_w[ST_RELAY] = relay_q;
    status_w[ST_HOLD] = hold_busy;
    status_w[ST_DELAY] = delay_busy;
    status_w[ST_LAMP] = lamp_on_q;
  end

  // reads take one wait state so a write just before is always seen
  always_comb begin
    lamp_cfg_d = lamp_cfg_q;
    relay_cfg_d = relay_cfg_q;
    wr_pend_d = 1'b0;
    rd_pend_d = 1'b0;
    ofs_d = ofs_q;
    hrdata_d = HRDATA;
    hready_d = 1'b1;
    if (wr_pend_q) begin
      unique case (ofs_q)
        OFS_LAMP_CTRL: begin
          lamp_cfg_d.mode = HWDATA[F_MODE_LO +: MODE_W];
          lamp_cfg_d.act_scene = HWDATA[F_ACT];
          lamp_cfg_d.auto_off = HWDATA[F_AUTO];
        end
        OFS_LAMP_VAL: begin
          // levels above the top of range are held at the top
          if (HWDATA[F_LEVEL_LO +: LEVEL_W] > LEVEL_MAX) begin
            lamp_cfg_d.level = LEVEL_MAX;
          end else begin
            lamp_cfg_d.level = HWDATA[F_LEVEL_LO +: LEVEL_W];
          end
          lamp_cfg_d.scene = HWDATA[F_SCENE_LO +: SCENE_W];
        end
        OFS_LAMP_DELAY: begin
          lamp_cfg_d.dmin = HWDATA[F_MIN_LO +: TIME_FLD_W];
          lamp_cfg_d.dsec = HWDATA[F_SEC_LO +: TIME_FLD_W];
        end
        OFS_RELAY_CTRL: begin
          relay_cfg_d.mode = HWDATA[F_MODE_LO +: MODE_W];
          relay_cfg_d.act_on = HWDATA[F_ACT];
          relay_cfg_d.toggle = HWDATA[F_AUTO];
        end
        OFS_RELAY_HOLD: begin
          relay_cfg_d.hmin = HWDATA[F_MIN_LO +: TIME_FLD_W];
          relay_cfg_d.hsec = HWDATA[F_SEC_LO +: TIME_FLD_W];
        end
        default: begin
        end
      endcase
    end
    if (rd_pend_q) begin
      hrdata_d = '0;
      unique case (ofs_q)
        OFS_LAMP_CTRL: begin
          hrdata_d[F_MODE_LO +: MODE_W] = lamp_cfg_q.mode;
          hrdata_d[F_ACT] = lamp_cfg_q.act_scene;
          hrdata_d[F_AUTO] = lamp_cfg_q.auto_off;
        end
        OFS_LAMP_VAL: begin
          hrdata_d[F_LEVEL_LO +: LEVEL_W] = lamp_cfg_q.level;
          hrdata_d[F_SCENE_LO +: SCENE_W] = lamp_cfg_q.scene;
        end
        OFS_LAMP_DELAY: begin
          hrdata_d[F_MIN_LO +: TIME_FLD_W] = lamp_cfg_q.dmin;
          hrdata_d[F_SEC_LO +: TIME_FLD_W] = lamp_cfg_q.dsec;
        end
        OFS_RELAY_CTRL: begin
          hrdata_d[F_MODE_LO +: MODE_W] = relay_cfg_q.mode;
          hrdata_d[F_ACT] = relay_cfg_q.act_on;
          hrdata_d[F_AUTO] = relay_cfg_q.toggle;
        end
        OFS_RELAY_HOLD: begin
          hrdata_d[F_MIN_LO +: TIME_FLD_W] = relay_cfg_q.hmin;
          hrdata_d[F_SEC_LO +: TIME_FLD_W] = relay_cfg_q.hsec;
        end
        OFS_STATUS: hrdata_d = status_w;
        default: hrdata_d = '0; // unmapped reads as zero
      endcase
    end
    if (addr_ok) begin
      // upper address bits beyond the map alias to no register
      ofs_d = (HADDR[ADDR_W-1:OFS_W] == '0) ? HADDR[OFS_W-1:0] : OFS_W'(8'hff);
      wr_pend_d = HWRITE;
      rd_pend_d = !HWRITE;
      hready_d = HWRITE;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      lamp_cfg_q <= LAMP_CFG_RST;
      relay_cfg_q <= RELAY_CFG_RST;
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      ofs_q <= '0;
      HRDATA <= '0;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      lamp_cfg_q <= lamp_cfg_d;
      relay_cfg_q <= relay_cfg_d;
      wr_pend_q <= wr_pend_d;
      rd_pend_q <= rd_pend_d;
      ofs_q <= ofs_d;
      HRDATA <= hrdata_d;
      HREADYOUT <= hready_d;
      HRESP <= 1'b0;
    end
  end

  // ---------------- timers ----------------
  logic tick;
  logic lamp_det, lamp_vac, relay_det;
  logic delay_load, delay_cancel, hold_load, hold_cancel;

  oeac_tick #(
    .PERIOD(TICK_CYCLES_P)
  ) u_tick (
    .clk(CORE_CLK),
    .rst(RST),
    .tick_q(tick)
  );

  oeac_countdown #(
    .W(SECS_W)
  ) u_delay (
    .clk(CORE_CLK),
    .rst(RST),
    .load(delay_load),
    .load_val(to_secs(lamp_cfg_q.dmin, lamp_cfg_q.dsec)),
    .cancel(delay_cancel),
    .tick(tick),
    .busy_q(delay_busy),
    .done_q(delay_done)
  );

  oeac_countdown #(
    .W(SECS_W)
  ) u_hold (
    .clk(CORE_CLK),
    .rst(RST),
    .load(hold_load),
    .load_val(to_secs(relay_cfg_q.hmin, relay_cfg_q.hsec)),
    .cancel(hold_cancel),
    .tick(tick),
    .busy_q(hold_busy),
    .done_q(hold_done)
  );

  // ---------------- lamp actions ----------------
  oeac_lamp_cmd_t cmd_d;

  assign lamp_det = detect(lamp_cfg_q.mode, OCC_EVT, MOTION_EVT);
  assign lamp_vac = detect(lamp_cfg_q.mode, IDLE_EVT, NOMOTION_EVT);
  // every presence report, and a vacancy report while lamps are on, rearms the delay at full length
  assign delay_load = lamp_cfg_q.auto_off && (lamp_det || (lamp_vac && lamp_on_q));
  assign delay_cancel = !lamp_cfg_q.auto_off;

  // detection outranks an expiry in the same cycle, so lamps never drop on arrival
  always_comb begin
    cmd_d = '0;
    lamp_on_d = lamp_on_q;
    if (lamp_det) begin
      cmd_d.valid = 1'b1;
      lamp_on_d = 1'b1;
      if (lamp_cfg_q.act_scene) begin
        cmd_d.kind = CMD_SCENE;
        cmd_d.arg = {{(LEVEL_W-SCENE_W){1'b0}}, lamp_cfg_q.scene};
      end else begin
        cmd_d.kind = CMD_LEVEL;
        cmd_d.arg = lamp_cfg_q.level;
      end
    end else if (delay_done && lamp_cfg_q.auto_off) begin
      cmd_d.valid = 1'b1;
      cmd_d.kind = CMD_OFF;
      lamp_on_d = 1'b0;
    end
  end

  // ---------------- relay actions ----------------
  assign relay_det = detect(relay_cfg_q.mode, OCC_EVT, MOTION_EVT);
  assign hold_load = relay_det && relay_cfg_q.toggle;
  assign hold_cancel = relay_det && !relay_cfg_q.toggle;

  // the former state is kept only from before the first detection of a hold
  always_comb begin
    relay_d = relay_q;
    saved_d = saved_q;
    if (relay_det) begin
      relay_d = relay_cfg_q.act_on;
      if (!hold_busy) begin
        saved_d = relay_q;
      end
    end else if (hold_done) begin
      relay_d = saved_q;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      LAMP_CMD <= '0;
      lamp_on_q <= 1'b0;
      relay_q <= 1'b0;
      saved_q <= 1'b0;
      RELAY_ON <= 1'b0;
    end else begin
      LAMP_CMD <= cmd_d;
      lamp_on_q <= lamp_on_d;
      relay_q <= relay_d;
      saved_q <= saved_d;
      RELAY_ON <= relay_d;
    end
  end
endmodule : oeac_top

// >>> dv/oeac_sensor.sv
// behavioural occupancy and motion sensor on the lighting bus side
`timescale 1ns/10ps
module oeac_sensor (
  input wire logic [3:0] req,
  input wire logic occ_rep,
  input wire logic mot_rep,
  output logic occ_evt,
  output logic idle_evt,
  output logic motion_evt,
  output logic nomotion_evt
);
  // a report leaves only when the sensor has that reporting switched on
  assign occ_evt = req[0] & occ_rep;
  assign idle_evt = req[1] & occ_rep;
  assign motion_evt = req[2] & mot_rep;
  assign nomotion_evt = req[3] & mot_rep;
endmodule : oeac_sensor

// >>> dv/oeac_top_chk.sv
// assertions on the controller's bus and lamp command ports
`timescale 1ns/10ps
module oeac_top_chk #(
  parameter int unsigned TICK_CYCLES_P = 20
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [oeac_pkg::DATA_W-1:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic OCC_EVT,
  input wire logic MOTION_EVT,
  input wire oeac_pkg::oeac_lamp_cmd_t LAMP_CMD
);
  import oeac_pkg::*;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // bus steps: accepted address phase, then one wait and the data for a read, the data with no wait for a write
  sequence s_rd_take;
    HSEL && HTRANS[1] && HREADY && !HWRITE;
  endsequence
  sequence s_wr_take;
    HSEL && HTRANS[1] && HREADY && HWRITE;
  endsequence
  sequence s_rd_data;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  a_read_one_wait: assert property (s_rd_take |=> s_rd_data)
    else $error("read data phase not two cycles");
  a_write_no_wait: assert property (s_wr_take |=> HREADYOUT)
    else $error("write data phase stalled");
  a_resp_always_okay: assert property (HRESP == 1'b0)
    else $error("error response seen");
  // read data only moves when a read completes
  a_rdata_held: assert property ($changed(HRDATA) |-> HREADYOUT && !$past(HREADYOUT))
    else $error("read data changed outside a read");
  a_level_in_range: assert property (
    LAMP_CMD.valid && LAMP_CMD.kind == CMD_LEVEL |-> LAMP_CMD.arg <= LEVEL_MAX)
    else $error("level above top");
  a_scene_in_range: assert property (
    LAMP_CMD.valid && LAMP_CMD.kind == CMD_SCENE |-> LAMP_CMD.arg < 8'h10)
    else $error("scene index out of range");
  a_off_arg_zero: assert property (
    LAMP_CMD.valid && LAMP_CMD.kind == CMD_OFF |-> LAMP_CMD.arg == 8'h00)
    else $error("off command with argument");
  // an on command always follows a detection one cycle earlier
  a_cmd_has_cause: assert property (
    LAMP_CMD.valid && LAMP_CMD.kind != CMD_OFF |-> $past(OCC_EVT) || $past(MOTION_EVT))
    else $error("lamp command without detection");
endmodule : oeac_top_chk

bind oeac_top oeac_top_chk #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_chk (
  .CORE_CLK, .RST, .HSEL, .HTRANS, .HWRITE, .HREADY, .HRDATA, .HREADYOUT, .HRESP,
  .OCC_EVT, .MOTION_EVT, .LAMP_CMD);

// >>> dv/occupancy_event_action_controller_test.sv
// self-checking bench for the occupancy event action controller
`timescale 1ns/10ps
module occupancy_event_action_controller_test;
  import oeac_pkg::*;
  localparam int T = 20;
  logic CORE_CLK = 1'b0;
  logic RST = 1'b1;
  logic HSEL = 1'b0;
  logic [ADDR_W-1:0] HADDR = '0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [2:0] HSIZE = 3'h0;
  logic [DATA_W-1:0] HWDATA = '0;
  logic [3:0] req = 4'h0;
  logic HREADY;
  logic [DATA_W-1:0] HRDATA;
  logic HREADYOUT;
  logic HRESP;
  logic OCC_EVT;
  logic IDLE_EVT;
  logic MOTION_EVT;
  logic NOMOTION_EVT;
  oeac_lamp_cmd_t LAMP_CMD;
  logic RELAY_ON;
  logic [31:0] rd;
  int n;
  int fail_count = 0;
  int tests_run = 0;
  // one slave, so its ready is the bus ready
  assign HREADY = HREADYOUT;

  oeac_top #(.TICK_CYCLES_P(T)) dut (
    .CORE_CLK(CORE_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .OCC_EVT(OCC_EVT), .IDLE_EVT(IDLE_EVT),
    .MOTION_EVT(MOTION_EVT), .NOMOTION_EVT(NOMOTION_EVT), .LAMP_CMD(LAMP_CMD),
    .RELAY_ON(RELAY_ON));

  oeac_sensor u_sensor (
    .req(req), .occ_rep(1'b1), .mot_rep(1'b1), .occ_evt(OCC_EVT), .idle_evt(IDLE_EVT),
    .motion_evt(MOTION_EVT), .nomotion_evt(NOMOTION_EVT));

  // 200 MHz core clock
  initial begin
    forever #2.5 CORE_CLK = ~CORE_CLK;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // single word transfer; no cycle count assumed, the watchdog ends a hang
  task automatic bus(input logic w, input logic [OFS_W-1:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= ADDR_W'(a);
    HWRITE <= w;
    HSIZE <= 3'h2;
    do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
  endtask : bus

  task automatic wr(input logic [OFS_W-1:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [OFS_W-1:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc

  // one-cycle sensor report; returns once the action should be visible
  task automatic sense(input int i);
    @(posedge CORE_CLK);
    req <= 4'(1 << i);
    @(posedge CORE_CLK);
    req <= 4'h0;
    #1;
  endtask : sense

  // steps past the edge first, since the last command may still stand
  task automatic wait_cmd(input int lim);
    n = 0;
    do begin
      @(posedge CORE_CLK);
      #1;
      n++;
    end while (LAMP_CMD.valid !== 1'b1 && n < lim);
  endtask : wait_cmd

  function automatic logic [31:0] cmd();
    return {21'h0, LAMP_CMD};
  endfunction : cmd

  function automatic logic [31:0] vld();
    return {31'h0, LAMP_CMD.valid};
  endfunction : vld

  function automatic logic [31:0] ec(input oeac_cmd_kind_t k, input logic [7:0] a);
    return {21'h0, 1'b1, k, a};
  endfunction : ec

  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge CORE_CLK);
    fail_count++;
    test_done();
  end

  // main sequence
  initial begin
    repeat (10) @(posedge CORE_CLK);
    RST <= 1'b0;
    @(posedge CORE_CLK);
    rdc(OFS_STATUS, 32'h0);
    rdc(8'h40, 32'h0);
    chk(32'(RELAY_ON), 32'h0);
    for (int m = 0; m < 4; m += 3) begin
      wr(OFS_LAMP_CTRL, 32'(m));
      sense(0);
      chk(vld(), 32'h0);
    end
    wr(OFS_LAMP_VAL, 32'h64);
    wr(OFS_LAMP_CTRL, 32'h1);
    sense(0);
    chk(cmd(), ec(CMD_LEVEL, 8'h64));
    sense(2);
    chk(vld(), 32'h0);
    wr(OFS_LAMP_VAL, 32'hfff);
    rdc(OFS_LAMP_VAL, 32'hffe);
    wr(OFS_LAMP_CTRL, 32'h6);
    sense(2);
    chk(cmd(), ec(CMD_SCENE, 8'h0f));
    sense(0);
    chk(vld(), 32'h0);
    // timed switch-off, restarted by a fresh detection
    wr(OFS_LAMP_DELAY, 32'h2);
    wr(OFS_LAMP_CTRL, 32'h9);
    sense(0);
    chk(cmd(), ec(CMD_LEVEL, 8'hfe));
    sense(1);
    repeat (30) @(posedge CORE_CLK);
    sense(0);
    chk(cmd(), ec(CMD_LEVEL, 8'hfe));
    wait_cmd(4 * T);
    chk(cmd(), ec(CMD_OFF, 8'h00));
    chk(32'(n >= 2 * T - 2 && n <= 3 * T + 2), 32'h1);
    // without auto-off the lamps stay on
    wr(OFS_LAMP_CTRL, 32'h1);
    sense(0);
    sense(1);
    wait_cmd(4 * T);
    chk(32'(n), 32'(4 * T));
    // relay latched, then disabled, then toggled with a hold
    wr(OFS_LAMP_CTRL, 32'h0);
    wr(OFS_RELAY_CTRL, 32'h5);
    sense(0);
    chk(32'(RELAY_ON), 32'h1);
    repeat (4 * T) @(posedge CORE_CLK);
    chk(32'(RELAY_ON), 32'h1);
    wr(OFS_RELAY_CTRL, 32'h0);
    sense(0);
    chk(32'(RELAY_ON), 32'h1);
    wr(OFS_RELAY_HOLD, 32'h1);
    wr(OFS_RELAY_CTRL, 32'ha);
    sense(0);
    chk(32'(RELAY_ON), 32'h1);
    sense(2);
    chk(32'(RELAY_ON), 32'h0);
    n = 0;
    while (RELAY_ON !== 1'b1 && n < 3 * T) begin
      @(posedge CORE_CLK);
      #1;
      n++;
    end
    chk(32'(n >= T - 2 && n <= 2 * T + 2), 32'h1);
    rdc(OFS_STATUS, 32'h9);
    test_done();
  end
endmodule : occupancy_event_action_controller_test
